//--- tb.sv
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, rst_pin_n, osc_stop, osc_stable, cpu_sleep, pins_hiz;
	logic io_we, io_re, reg_we, reg_re;
	logic [3:0] clock_source_select;
	logic [2:0] clk_src;
	logic [9:0] pm_addr, pa;
	logic [15:0] pm_rdata, reg_wdata, reg_rdata, er;
	logic [5:0] io_addr;
	logic [7:0] io_wdata, io_rdata, irq_req, irq_ack, irq_set;
	logic [1:0] reg_addr;
	logic [31:0] ev, got_ev, seed = 32'd44779, r;
	logic [31:0] exp_q[$];
	logic [15:0] reg_q[$];
	logic rd_d = 1'b0;
	int miscompares = 0;
	int total_checks = 0;
	// tail: pointer setup, flash byte load, indirect store/load, zero branch skipping a word
	localparam logic [15:0] PROG [0:24] = '{16'h305A, 16'h3133, 16'h1211, 16'h5805, 16'h4905,
		16'h5906, 16'h7019, 16'h5888, 16'h0004, 16'h0003, 16'h580A, 16'h0003, 16'h588B,
		16'h3E21, 16'h3F00, 16'h0006, 16'h500C, 16'h2E20, 16'h2840, 16'h510D, 16'h1631,
		16'h8001, 16'h580E, 16'h588F, 16'h63FF};
	localparam logic [31:0] EVT [0:12] = '{32'h0105008D, 32'h0106008D, 32'h0107008D,
		32'h01080033, 32'h02020000, 32'h01090033, 32'h02040000, 32'h010A008D, 32'h02010000,
		32'h010B0033, 32'h010C0030, 32'h010D0033, 32'h010F0000};

	trc_core trc_core_i (.clk, .srst, .rst_pin_n, .clock_source_select, .clk_src, .osc_stop,
		.osc_stable, .cpu_sleep, .pins_hiz, .pm_addr, .pm_rdata, .io_addr, .io_wdata, .io_we,
		.io_re, .io_rdata, .irq_req, .irq_ack, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
	trc_mem_model trc_mem_model_i (.clk, .pm_addr, .pm_rdata, .io_addr, .io_wdata, .io_we,
		.io_re, .io_rdata, .irq_set, .irq_ack, .irq_req, .osc_stop, .osc_stable);

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [2:0] src_of(input logic [3:0] v);
		if (v >= 4'hA) return 3'h4;
		if (v >= 4'h8) return 3'h3;
		if (v >= 4'h5) return 3'h2;
		if (v >= 4'h2) return 3'h1;
		return 3'h0;
	endfunction
	function bit cnd(input int s);
		case (s)
			0: return cpu_sleep === 1'b1;
			1: return cpu_sleep === 1'b0;
			2: return osc_stop === 1'b0;
			default: return exp_q.size() == 0;
		endcase
	endfunction

	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wait_c(input int s);
		int n;
		n = 0;
		while (!cnd(s)) begin
			@(posedge clk);
			n++;
			if (n > 3000) begin
				miscompares++;
				$display("BAD wait %0d exp 1 got 0", s);
				stop_test();
			end
		end
	endtask
	task reg_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task reg_rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		reg_q.push_back(e);
		@(posedge clk);
		reg_re <= 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// results are compared in the order they leave the core
	always @(posedge clk) begin
		if (io_we === 1'b1 || irq_ack != 8'h00) begin
			got_ev = io_we ? {8'h01, 2'b00, io_addr, 8'h00, io_wdata} : {8'h02, irq_ack, 16'h0000};
			ev = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
			`CHK("event", ev, got_ev)
		end
		if (rd_d) begin
			er = reg_q.size() ? reg_q.pop_front() : 16'hDEAD;
			`CHK("reg_rdata", er, reg_rdata)
		end
		rd_d = reg_re;
	end

	initial begin
		srst = 1'b1;
		rst_pin_n = 1'b1;
		clock_source_select = trc_pkg::CKSEL_SHIP;
		irq_set = 8'h00;
		reg_addr = 2'h0;
		reg_wdata = 16'h0000;
		reg_we = 1'b0;
		reg_re = 1'b0;
		for (int i = 0; i < 1024; i++) trc_mem_model_i.rom[i] = 16'h0000;
		trc_mem_model_i.rom[0] = 16'h600F;
		trc_mem_model_i.rom[1] = 16'h0002;
		trc_mem_model_i.rom[2] = 16'h5889;
		trc_mem_model_i.rom[3] = 16'h0002;
		trc_mem_model_i.rom[48] = 16'h5807;
		trc_mem_model_i.rom[49] = 16'h0001;
		for (int i = 0; i < 25; i++) trc_mem_model_i.rom[16 + i] = PROG[i];
		for (int i = 0; i < 13; i++) exp_q.push_back(EVT[i]);
		repeat (6) @(posedge clk);
		`CHK("hiz", 1'b1, pins_hiz)
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		reg_rd(trc_pkg::REG_STAT, 16'h0000);
		reg_rd(trc_pkg::REG_CLK, 16'h0012);
		`CHK("clk_src", 3'h1, clk_src)
		wait_c(0);
		`CHK("osc_stop", 1'b0, osc_stop)
		pa = pm_addr;
		repeat (8) @(posedge clk);
		`CHK("pm_addr", pa, pm_addr)
		r = rnd();
		reg_wr(trc_pkg::REG_CTRL, {r[15:2], 2'b01});
		reg_rd(trc_pkg::REG_CTRL, 16'h0001);
		@(posedge clk) irq_set <= 8'h06;
		@(posedge clk) irq_set <= 8'h00;
		wait_c(1);
		wait_c(0);
		repeat (2) @(posedge clk);
		`CHK("osc_stop", 1'b1, osc_stop)
		@(posedge clk) irq_set <= 8'h01;
		@(posedge clk) irq_set <= 8'h00;
		wait_c(2);
		repeat (3) @(posedge clk);
		`CHK("cpu_sleep", 1'b1, cpu_sleep)
		wait_c(3);
		// hold bit freezes the fetch in the closing jump loop
		reg_wr(trc_pkg::REG_CTRL, 16'h0002);
		@(posedge clk);
		pa = pm_addr;
		repeat (4) @(posedge clk);
		`CHK("pm_addr", pa, pm_addr)
		repeat (4) @(posedge clk);
		`CHK("hiz", 1'b0, pins_hiz)
		// pin held low four cycles, well beyond the minimum pulse
		@(posedge clk) rst_pin_n <= 1'b0;
		#1 `CHK("hiz", 1'b1, pins_hiz)
		repeat (4) @(posedge clk);
		`CHK("pm_addr", 10'h000, pm_addr)
		rst_pin_n <= 1'b1;
		r = rnd();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			clock_source_select <= 4'(i) + r[3:0];
			srst <= 1'b1;
			@(posedge clk) srst <= 1'b0;
			repeat (3) @(posedge clk);
			`CHK("clk_src", src_of(4'(i) + r[3:0]), clk_src)
		end
		stop_test();
	end
endmodule

//--- trc_core.sv
// How it works
// RULE1: thirty-two 8-bit registers, single-cycle access
// RULE2: read two operands, compute, write back
// RULE3: r31:r30 pointer addresses registers and flash
// RULE4: separate program and data buses
// RULE5: fetch next while current executes
// RULE6: each instruction is one 16-bit word
// RULE7: relative jump/call reach all 1K words
// RULE8: three-deep hardware return stack
// RULE9: 64-address I/O space decoded
// RULE10: one vector per interrupt at start
// RULE11: lowest vector wins when several pend
// RULE12: global enable gates all interrupts
// RULE13: idle stops execution, interrupts still run
// RULE14: power-down stops oscillator, keeps registers
// RULE15: 4-bit select field picks clock source
// RULE16: internal 1 MHz RC is shipped default
// RULE17: low reset pin resets without clock; here rst waits two clocked flops, only pins_hiz follows the raw pin
// RULE18: pins tri-stated while any reset active
// RULE19: program counter is 10 bits
// RULE20: stack overflow drops oldest return address
// RULE21: global enable is status bit 7
// RULE22: taken redirect discards prefetched word
// RULE23: wake waits for stable oscillator
module trc_core (
	input wire logic clk,
	input wire logic srst,
	input wire logic rst_pin_n,
	input wire logic [3:0] clock_source_select,
	output logic [2:0] clk_src,
	output logic osc_stop,
	input wire logic osc_stable,
	output logic cpu_sleep,
	output logic pins_hiz,
	output logic [9:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] irq_req,
	output logic [7:0] irq_ack,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [15:0] reg_rdata
);
	trc_rf_if rfi ();

	trc_regfile u_rf (
		.clk(clk),
		.rf(rfi.rf)
	);

	logic rpin_s1_ff;
	logic rpin_s2_ff;
	logic osc_s1_ff;
	logic osc_s2_ff;
	logic rst;
	logic cap_done_ff;
	logic [3:0] cksel_ff;
	trc_pkg::trc_clk_src_t clk_src_ff;
	logic [9:0] pc_ff;
	logic [9:0] nxt_pc;
	logic [15:0] ir_ff;
	logic [15:0] nxt_ir;
	logic irv_ff;
	logic nxt_irv;
	trc_pkg::trc_state_t st_ff;
	trc_pkg::trc_state_t nxt_st;
	logic [7:0] sreg_ff;
	logic [9:0] stk_ff [trc_pkg::STK_N];
	logic [1:0] ctrl_ff;
	logic [15:0] rd_ff;
	logic [3:0] op;
	logic [1:0] fn;
	logic [3:0] sub;
	logic [4:0] rd5;
	logic [4:0] rr5;
	logic [4:0] iod;
	logic [5:0] ioa;
	logic [9:0] rel_tgt;
	logic hold;
	logic exec;
	logic irq_hit;
	logic [2:0] irq_idx;
	logic take_irq;
	logic push;
	logic pop;
	logic [9:0] ret_addr;
	logic [8:0] res;
	logic flag_upd;
	logic carry_upd;
	logic [7:0] lpm_byte;

	// RULE17: reset pin sampled
	always_ff @(posedge clk) begin
		if (srst) begin
			rpin_s1_ff <= 1'b1;
			rpin_s2_ff <= 1'b1;
		end else begin
			rpin_s1_ff <= rst_pin_n;
			rpin_s2_ff <= rpin_s1_ff;
		end
	end

	assign rst = srst | ~rpin_s2_ff;

	// RULE18: pins float now
	// the raw pin term acts even with the clock stopped
	assign pins_hiz = ~rst_pin_n | rst;

	always_ff @(posedge clk) begin
		if (srst) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
		end else begin
			osc_s1_ff <= osc_stable;
			osc_s2_ff <= osc_s1_ff;
		end
	end

	// RULE16: shipped internal RC
	// the fuse field is static, so one capture after reset is enough
	always_ff @(posedge clk) begin
		if (rst) begin
			cap_done_ff <= 1'b0;
			cksel_ff <= trc_pkg::CKSEL_SHIP;
		end else if (!cap_done_ff) begin
			cap_done_ff <= 1'b1;
			cksel_ff <= clock_source_select;
		end
	end

	// RULE15: select field decode
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_src_ff <= trc_pkg::CS_IRC;
		end else if (cksel_ff >= trc_pkg::CKS_XTAL_MIN) begin
			clk_src_ff <= trc_pkg::CS_XTAL;
		end else if (cksel_ff >= trc_pkg::CKS_LFX_MIN) begin
			clk_src_ff <= trc_pkg::CS_LFX;
		end else if (cksel_ff >= trc_pkg::CKS_ERC_MIN) begin
			clk_src_ff <= trc_pkg::CS_ERC;
		end else if (cksel_ff >= trc_pkg::CKS_IRC_MIN) begin
			clk_src_ff <= trc_pkg::CS_IRC;
		end else begin
			clk_src_ff <= trc_pkg::CS_EXT;
		end
	end

	assign clk_src = clk_src_ff;

	// RULE6: one word decode
	assign op = ir_ff[15:12];
	assign fn = ir_ff[11:10];
	assign sub = ir_ff[3:0];
	assign rd5 = ir_ff[9:5];
	assign rr5 = ir_ff[4:0];
	assign iod = ir_ff[11:7];
	assign ioa = ir_ff[5:0];
	// RULE7: offset wraps the space
	// pc_ff already points one past the executing word
	assign rel_tgt = pc_ff + ir_ff[9:0];

	assign hold = ctrl_ff[trc_pkg::CTRL_HOLD];

	// RULE11: lowest index wins
	always_comb begin
		irq_idx = 3'h0;
		for (int i = trc_pkg::IRQ_N - 1; i >= 0; i--) begin
			if (irq_req[i]) begin
				irq_idx = 3'(i);
			end
		end
	end

	assign irq_hit = |irq_req;
	// RULE12: global enable gate
	assign take_irq = (st_ff == trc_pkg::ST_RUN) & !hold & irq_hit
		& sreg_ff[trc_pkg::SREG_I];
	assign exec = (st_ff == trc_pkg::ST_RUN) & !hold & irv_ff & !take_irq;

	always_comb begin
		irq_ack = 8'h00;
		if (take_irq) begin
			irq_ack[irq_idx] = 1'b1;
		end
	end

	// an interrupt in a bubble returns to the word about to be fetched
	assign ret_addr = take_irq ? (irv_ff ? pc_ff - 10'h001 : pc_ff) : pc_ff;

	// RULE4: separate program bus
	// RULE3: pointer reads flash
	assign pm_addr = (st_ff == trc_pkg::ST_LPM) ? rfi.z[10:1] : pc_ff;
	assign lpm_byte = rfi.z[0] ? pm_rdata[15:8] : pm_rdata[7:0];

	// RULE9: I/O decode
	// the status register lives here; the other 63 go to the peripherals
	assign io_addr = ioa;
	assign io_wdata = rfi.da;
	assign io_we = exec & (op == trc_pkg::OP_OUT) & (ioa != trc_pkg::IO_SREG);
	assign io_re = exec & (op == trc_pkg::OP_IN) & (ioa != trc_pkg::IO_SREG);

	always_comb begin
		rfi.ra = rd5;
		rfi.rb = rr5;
		if (op == trc_pkg::OP_OUT) begin
			rfi.ra = iod;
		end
		// RULE3: pointer reads registers
		if (op == trc_pkg::OP_MOV && fn == trc_pkg::FN_LD) begin
			rfi.rb = rfi.z[4:0];
		end
	end

	// RULE2: operate and write back
	always_comb begin
		res = {1'b0, rfi.db};
		rfi.we = 1'b0;
		rfi.wa = rd5;
		flag_upd = 1'b0;
		carry_upd = 1'b0;
		case (op)
			trc_pkg::OP_ALU: begin
				rfi.we = exec;
				flag_upd = exec;
				case (fn)
					trc_pkg::FN_ADD: begin
						res = {1'b0, rfi.da} + {1'b0, rfi.db};
						carry_upd = exec;
					end
					trc_pkg::FN_SUB: begin
						res = {1'b0, rfi.da} - {1'b0, rfi.db};
						carry_upd = exec;
					end
					trc_pkg::FN_AND: begin
						res = {1'b0, rfi.da & rfi.db};
					end
					default: begin
						res = {1'b0, rfi.da | rfi.db};
					end
				endcase
			end
			trc_pkg::OP_MOV: begin
				rfi.we = exec;
				case (fn)
					trc_pkg::FN_EOR: begin
						res = {1'b0, rfi.da ^ rfi.db};
						flag_upd = exec;
					end
					trc_pkg::FN_ST: begin
						res = {1'b0, rfi.da};
						rfi.wa = rfi.z[4:0];
					end
					default: begin
						res = {1'b0, rfi.db};
					end
				endcase
			end
			trc_pkg::OP_LDI: begin
				rfi.we = exec;
				rfi.wa = {1'b1, ir_ff[11:8]};
				res = {1'b0, ir_ff[7:0]};
			end
			trc_pkg::OP_IN: begin
				rfi.we = exec;
				rfi.wa = iod;
				res = {1'b0, (ioa == trc_pkg::IO_SREG) ? sreg_ff : io_rdata};
			end
			default: begin
				res = {1'b0, rfi.db};
			end
		endcase
		if (st_ff == trc_pkg::ST_LPM) begin
			rfi.we = 1'b1;
			rfi.wa = 5'h00;
			res = {1'b0, lpm_byte};
		end
	end

	// RULE1: single-cycle write
	assign rfi.wd = res[7:0];

	always_comb begin
		nxt_pc = pc_ff;
		nxt_ir = ir_ff;
		nxt_irv = irv_ff;
		nxt_st = st_ff;
		push = 1'b0;
		pop = 1'b0;
		case (st_ff)
			trc_pkg::ST_RUN: begin
				if (hold) begin
					nxt_st = st_ff;
				end else if (take_irq) begin
					// RULE10: per-source vector
					nxt_pc = 10'(irq_idx) + 10'h001;
					nxt_irv = 1'b0;
					push = 1'b1;
				end else begin
					// RULE5: prefetch next word
					// RULE19: 10-bit counter
					nxt_pc = pc_ff + 10'h001;
					nxt_ir = pm_rdata;
					nxt_irv = 1'b1;
					if (exec) begin
						case (op)
							trc_pkg::OP_RJMP: begin
								// RULE22: discard prefetch
								nxt_pc = rel_tgt;
								nxt_irv = 1'b0;
							end
							trc_pkg::OP_RCALL: begin
								nxt_pc = rel_tgt;
								nxt_irv = 1'b0;
								push = 1'b1;
							end
							trc_pkg::OP_BRZ: begin
								if (sreg_ff[trc_pkg::SREG_Z]) begin
									nxt_pc = rel_tgt;
									nxt_irv = 1'b0;
								end
							end
							trc_pkg::OP_MISC: begin
								if (sub == trc_pkg::MS_RET || sub == trc_pkg::MS_RETI) begin
									nxt_pc = stk_ff[0];
									nxt_irv = 1'b0;
									pop = 1'b1;
								end else if (sub == trc_pkg::MS_SLEEP) begin
									// the prefetched word stays and runs after wake;
									// keeping the sleep word itself would sleep again
									nxt_st = ctrl_ff[trc_pkg::CTRL_PD] ? trc_pkg::ST_PDOWN
										: trc_pkg::ST_IDLE;
								end else if (sub == trc_pkg::MS_LPM) begin
									nxt_pc = pc_ff;
									nxt_irv = 1'b0;
									nxt_st = trc_pkg::ST_LPM;
								end
							end
							default: begin
								nxt_st = st_ff;
							end
						endcase
					end
				end
			end
			trc_pkg::ST_LPM: begin
				// flash port was borrowed, so refetch from pc
				nxt_st = trc_pkg::ST_RUN;
			end
			trc_pkg::ST_IDLE: begin
				// RULE13: idle until interrupt
				if (irq_hit) begin
					nxt_st = trc_pkg::ST_RUN;
				end
			end
			trc_pkg::ST_PDOWN: begin
				// RULE14: oscillator stopped
				if (irq_hit) begin
					nxt_st = trc_pkg::ST_WAKE;
				end
			end
			trc_pkg::ST_WAKE: begin
				// RULE23: wait stable clock
				if (osc_s2_ff) begin
					nxt_st = trc_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_st = trc_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_ff <= trc_pkg::PC_RESET;
			ir_ff <= 16'h0000;
			irv_ff <= 1'b0;
			st_ff <= trc_pkg::ST_RUN;
		end else begin
			pc_ff <= nxt_pc;
			ir_ff <= nxt_ir;
			irv_ff <= nxt_irv;
			st_ff <= nxt_st;
		end
	end

	assign osc_stop = (st_ff == trc_pkg::ST_PDOWN);
	assign cpu_sleep = (st_ff != trc_pkg::ST_RUN) & (st_ff != trc_pkg::ST_LPM);

	// RULE8: three-deep stack
	// RULE20: oldest falls off
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < trc_pkg::STK_N; i++) begin
				stk_ff[i] <= 10'h000;
			end
		end else if (push) begin
			stk_ff[0] <= ret_addr;
			for (int i = 1; i < trc_pkg::STK_N; i++) begin
				stk_ff[i] <= stk_ff[i - 1];
			end
		end else if (pop) begin
			for (int i = 0; i < trc_pkg::STK_N - 1; i++) begin
				stk_ff[i] <= stk_ff[i + 1];
			end
		end
	end

	// RULE21: enable is bit 7
	always_ff @(posedge clk) begin
		if (rst) begin
			sreg_ff <= trc_pkg::SREG_RESET;
		end else if (take_irq) begin
			sreg_ff[trc_pkg::SREG_I] <= 1'b0;
		end else if (exec) begin
			if (op == trc_pkg::OP_OUT && ioa == trc_pkg::IO_SREG) begin
				sreg_ff <= rfi.da;
			end else if (op == trc_pkg::OP_MISC && sub == trc_pkg::MS_RETI) begin
				sreg_ff[trc_pkg::SREG_I] <= 1'b1;
			end else if (op == trc_pkg::OP_MISC && sub == trc_pkg::MS_SEI) begin
				sreg_ff[trc_pkg::SREG_I] <= 1'b1;
			end else if (op == trc_pkg::OP_MISC && sub == trc_pkg::MS_CLI) begin
				sreg_ff[trc_pkg::SREG_I] <= 1'b0;
			end else begin
				if (flag_upd) begin
					sreg_ff[trc_pkg::SREG_Z] <= (res[7:0] == 8'h00);
				end
				if (carry_upd) begin
					sreg_ff[trc_pkg::SREG_C] <= res[8];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= trc_pkg::CTRL_RESET;
		end else if (reg_we && reg_addr == trc_pkg::REG_CTRL) begin
			ctrl_ff <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ff <= 16'h0000;
		end else if (reg_re) begin
			case (reg_addr)
				trc_pkg::REG_CTRL: rd_ff <= {14'h0000, ctrl_ff};
				trc_pkg::REG_STAT: rd_ff <= {sreg_ff, 5'h00, st_ff};
				trc_pkg::REG_PC: rd_ff <= {6'h00, pc_ff};
				default: rd_ff <= {9'h000, clk_src_ff, cksel_ff};
			endcase
		end else begin
			rd_ff <= 16'h0000;
		end
	end

	assign reg_rdata = rd_ff;
endmodule

//--- trc_core_sva.sv
module trc_core_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic rst_pin_n,
	input wire logic osc_stop,
	input wire logic osc_stable,
	input wire logic cpu_sleep,
	input wire logic pins_hiz,
	input wire logic [9:0] pm_addr,
	input wire logic [15:0] pm_rdata,
	input wire logic [5:0] io_addr,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [7:0] irq_req,
	input wire logic [7:0] irq_ack
);
	logic [9:0] ack_vec;

	default clocking @(posedge clk); endclocking
	// a pin reset also redirects the pc, so it cancels attempts like srst does
	default disable iff (srst || !rst_pin_n);

	always_comb begin
		ack_vec = 10'h000;
		for (int i = 0; i < 8; i++) begin
			if (irq_ack[i]) begin
				ack_vec = 10'(i + 1);
			end
		end
	end

	// a jump word fetched and not squashed: prefetch went on to the next word
	sequence jmp_fetch_s;
		pm_rdata[15:12] == trc_pkg::OP_RJMP && !cpu_sleep ##1
			pm_addr == $past(pm_addr) + 10'h001 && irq_ack == 8'h00 && !cpu_sleep;
	endsequence

	sequence pd_stay_s;
		cpu_sleep ##1 osc_stop;
	endsequence

	hiz_on_reset_a:
	assert property (@(posedge clk) disable iff (srst) !rst_pin_n |-> pins_hiz)
		else $error("pins driven while reset pin is low");
	ack_onehot_a:
	assert property (irq_ack != 8'h00 |-> $onehot(irq_ack) && (irq_ack & ~irq_req) == 8'h00)
		else $error("acknowledge not one-hot or not requested");
	ack_lowest_a:
	assert property (irq_ack != 8'h00 |-> ((irq_ack - 8'h01) & irq_req) == 8'h00)
		else $error("lower request pending but not chosen");
	vec_fetch_a:
	assert property (irq_ack != 8'h00 |=> pm_addr == $past(ack_vec))
		else $error("fetch after entry not at its vector");
	jmp_target_a:
	assert property (jmp_fetch_s |=>
		pm_addr == $past(pm_addr, 2) + $past(pm_rdata[9:0], 2) + 10'h001)
		else $error("relative jump lands at wrong word");
	idle_quiet_a:
	assert property (cpu_sleep [*2] |-> !io_we && !io_re && $stable(pm_addr))
		else $error("core active while asleep");
	pd_hold_a:
	assert property (osc_stop && irq_req == 8'h00 |-> pd_stay_s)
		else $error("power-down left without a wake cause");
	wake_wait_a:
	assert property ($fell(osc_stop) && !osc_stable |-> cpu_sleep [*3])
		else $error("execution resumed before clock stable");
	io_space_a:
	assert property (io_we || io_re |-> io_addr != trc_pkg::IO_SREG)
		else $error("status register access leaked to the bus");
endmodule

bind trc_core trc_core_sva trc_core_sva_i (.clk, .srst, .rst_pin_n, .osc_stop, .osc_stable,
	.cpu_sleep, .pins_hiz, .pm_addr, .pm_rdata, .io_addr, .io_we, .io_re, .irq_req, .irq_ack);

//--- trc_mem_model.sv
module trc_mem_model (
	input wire logic clk,
	input wire logic [9:0] pm_addr,
	output logic [15:0] pm_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [7:0] io_rdata,
	input wire logic [7:0] irq_set,
	input wire logic [7:0] irq_ack,
	output logic [7:0] irq_req,
	input wire logic osc_stop,
	output logic osc_stable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rom [0:1023];
	logic [7:0] io_ff [0:63];
	logic [7:0] last_ff = 8'h00;
	logic [7:0] pend_ff = 8'h00;
	logic [3:0] start_ff = 4'hC;

	assign pm_rdata = rom[pm_addr];
	// released data bus shows the inverse so a stale sample cannot pass
	assign io_rdata = io_re ? io_ff[io_addr] : ~last_ff;
	assign irq_req = pend_ff;
	assign osc_stable = (start_ff == 4'hC);

	always_ff @(posedge clk) begin
		if (io_we) begin
			io_ff[io_addr] <= io_wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (io_re) begin
			last_ff <= io_ff[io_addr];
		end
	end
	always_ff @(posedge clk) begin
		pend_ff <= (pend_ff & ~irq_ack) | irq_set;
	end
	// oscillator needs twelve cycles to settle after a stop
	always_ff @(posedge clk) begin
		if (osc_stop) begin
			start_ff <= 4'h0;
		end else if (start_ff != 4'hC) begin
			start_ff <= start_ff + 4'h1;
		end
	end
endmodule

//--- trc_pkg.sv
package trc_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned RST_PULSE_NS = 50;
	localparam int unsigned RST_PULSE_CYC =
		(RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned RC_NOM_HZ = 1_000_000;
	localparam int unsigned PC_W = 10;
	localparam int unsigned RF_N = 32;
	localparam int unsigned STK_N = 3;
	localparam int unsigned IRQ_N = 8;
	localparam logic [9:0] PC_RESET = 10'h000;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [5:0] IO_SREG = 6'h3F;
	localparam int unsigned SREG_I = 7;
	localparam int unsigned SREG_Z = 1;
	localparam int unsigned SREG_C = 0;
	localparam logic [3:0] OP_MISC = 4'h0;
	localparam logic [3:0] OP_ALU = 4'h1;
	localparam logic [3:0] OP_MOV = 4'h2;
	localparam logic [3:0] OP_LDI = 4'h3;
	localparam logic [3:0] OP_IN = 4'h4;
	localparam logic [3:0] OP_OUT = 4'h5;
	localparam logic [3:0] OP_RJMP = 4'h6;
	localparam logic [3:0] OP_RCALL = 4'h7;
	localparam logic [3:0] OP_BRZ = 4'h8;
	localparam logic [3:0] MS_RET = 4'h1;
	localparam logic [3:0] MS_RETI = 4'h2;
	localparam logic [3:0] MS_SLEEP = 4'h3;
	localparam logic [3:0] MS_SEI = 4'h4;
	localparam logic [3:0] MS_CLI = 4'h5;
	localparam logic [3:0] MS_LPM = 4'h6;
	localparam logic [1:0] FN_ADD = 2'h0;
	localparam logic [1:0] FN_SUB = 2'h1;
	localparam logic [1:0] FN_AND = 2'h2;
	localparam logic [1:0] FN_MOV = 2'h0;
	localparam logic [1:0] FN_EOR = 2'h1;
	localparam logic [1:0] FN_LD = 2'h2;
	localparam logic [1:0] FN_ST = 2'h3;
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_PC = 2'h2;
	localparam logic [1:0] REG_CLK = 2'h3;
	localparam int unsigned CTRL_PD = 0;
	localparam int unsigned CTRL_HOLD = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [3:0] CKS_XTAL_MIN = 4'hA;
	localparam logic [3:0] CKS_LFX_MIN = 4'h8;
	localparam logic [3:0] CKS_ERC_MIN = 4'h5;
	localparam logic [3:0] CKS_IRC_MIN = 4'h2;
	localparam logic [3:0] CKSEL_SHIP = 4'h2;
	typedef enum logic [2:0] {CS_EXT, CS_IRC, CS_ERC, CS_LFX, CS_XTAL} trc_clk_src_t;
	typedef enum logic [2:0] {ST_RUN, ST_LPM, ST_IDLE, ST_PDOWN, ST_WAKE} trc_state_t;
endpackage

//--- trc_regfile.sv
module trc_regfile (
	input wire logic clk,
	trc_rf_if.rf rf
);
	// contents survive reset and sleep; only writes change them
	logic [7:0] mem_ff [trc_pkg::RF_N];

	always_ff @(posedge clk) begin
		if (rf.we) begin
			mem_ff[rf.wa] <= rf.wd;
		end
	end

	// two combinational read ports so operands and result share one cycle
	assign rf.da = mem_ff[rf.ra];
	assign rf.db = mem_ff[rf.rb];
	assign rf.z = {mem_ff[31], mem_ff[30]};
endmodule

//--- trc_rf_if.sv
interface trc_rf_if;
	logic [4:0] ra;
	logic [4:0] rb;
	logic [4:0] wa;
	logic [7:0] wd;
	logic we;
	logic [7:0] da;
	logic [7:0] db;
	logic [15:0] z;
	modport core (output ra, output rb, output wa, output wd, output we,
		input da, input db, input z);
	modport rf (input ra, input rb, input wa, input wd, input we,
		output da, output db, output z);
endinterface
